//--- ifca_access_port.sv
// Indirect access port from host registers to fabric control and status registers
//
// What this block does
// - Writing pending bit 31 starts fabric access
// - Pending stays set until fabric access completes
// - Read clears pending only after data captured
// - Direction bit 30: zero write, one read
// - Step-up: value write starts, then index plus one
// - Step-up: value read bumps index, starts read
// - Step-down: value write starts, then index minus
// - Step-down: value read drops index, starts read
// - Step-up wins when both step bits set
// - Lane select 19:16, lane n is byte n
// - Fabric write leaves unselected bytes unchanged
// - Target index 15:0 names the fabric register
// - Value register holds last read or write word
// - Value read gives fabric data or host word
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ifca_access_port #(
    parameter int ADDR_W = 12 // Host register address width
) (
    // Clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    // Host register port
    input  wire logic [ADDR_W-1:0]      reg_addr_in,
    input  wire logic [31:0]            reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [31:0]            reg_rdata_out,
    // Fabric register side
    output ifca_pkg::ifca_fab_req_t     fab_req_out,
    input  wire ifca_pkg::ifca_fab_rsp_t fab_rsp_in,
    input  wire logic [31:0]            fab_cur_in
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 12) begin : g_bad_width
        $error("ADDR_W too small for the register map");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {IFCA_IDLE, IFCA_ISSUE, IFCA_WAIT} ifca_state_t;

    ifca_state_t state;        // Access sequencer
    ifca_state_t next_state;   // Next sequencer state
    logic        pending;      // Access pending flag
    logic        dir_read;     // Direction bit
    logic        step_up;      // Auto step-up enable
    logic        step_down;    // Auto step-down enable
    logic [3:0]  lanes;        // Byte-lane select
    logic [15:0] index;        // Target index
    logic [31:0] host_word;    // Word last written by host
    logic [31:0] fab_word;     // Word last read from fabric
    logic        op_rd;        // Direction latched at launch
    logic [31:0] merged;       // Write word after lane merge

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire hit_cmd   = (reg_addr_in[11:0] == ifca_pkg::COMMAND_OFFSET);
    wire hit_val   = (reg_addr_in[11:0] == ifca_pkg::VALUE_OFFSET);
    wire wr_cmd    = reg_wr_in && hit_cmd;
    wire wr_val    = reg_wr_in && hit_val;
    wire rd_val    = reg_rd_in && hit_val;
    // Step-up takes precedence over step-down
    wire up_sel    = step_up;
    wire dn_sel    = step_down && !step_up;
    wire stepping  = up_sel || dn_sel;
    // Auto launches from value-register traffic
    wire auto_wr   = wr_val && stepping && !pending;
    wire auto_rd   = rd_val && stepping && dir_read && !pending;
    wire start_cmd = wr_cmd && reg_wdata_in[ifca_pkg::PENDING_BIT] && !pending;
    wire launch    = start_cmd || auto_wr || auto_rd;
    wire done      = (state == IFCA_WAIT) && fab_rsp_in.ack;
    // Index after a step: plus one or minus one
    wire [15:0] index_step = up_sel ? index + 16'h0001 : index - 16'h0001;

    // ------------------------------------------------------------
    // Lane merge for writes
    // ------------------------------------------------------------
    ifca_lane_merge #(
        .LANES (4)
    ) u_merge (
        .old_in     (fab_cur_in),
        .new_in     (host_word),
        .lanes_in   (lanes),
        .merged_out (merged)
    );

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            IFCA_IDLE: begin
                // Begin only on a launch
                if (launch) begin
                    next_state = IFCA_ISSUE;
                end
            end
            IFCA_ISSUE: begin
                next_state = IFCA_WAIT;
            end
            IFCA_WAIT: begin
                // Hold until the fabric answers
                if (fab_rsp_in.ack) begin
                    next_state = IFCA_IDLE;
                end
            end
            default: begin
                next_state = IFCA_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer and pending flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state   <= IFCA_IDLE;
            pending <= 1'b0;
            op_rd   <= 1'b0;
        end else begin
            state <= next_state;
            // Set on launch, held until completion
            if (launch) begin
                pending <= 1'b1;
                // Stored direction updates on this same edge, so take the written bit
                op_rd   <= start_cmd ? reg_wdata_in[ifca_pkg::DIRECTION_BIT] : auto_rd;
            end else if (done) begin
                pending <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Command fields
    // ------------------------------------------------------------
    // Writes while pending are dropped; software should not make them
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            dir_read  <= 1'b0;
            step_up   <= 1'b0;
            step_down <= 1'b0;
            lanes     <= ifca_pkg::LANE_RESET;
            index     <= ifca_pkg::INDEX_RESET;
        end else if (wr_cmd && !pending) begin
            dir_read  <= reg_wdata_in[ifca_pkg::DIRECTION_BIT];
            step_up   <= reg_wdata_in[ifca_pkg::STEP_UP_BIT];
            step_down <= reg_wdata_in[ifca_pkg::STEP_DOWN_BIT];
            lanes     <= reg_wdata_in[ifca_pkg::LANE_LSB +: 4];
            index     <= reg_wdata_in[ifca_pkg::INDEX_LSB +: 16];
        end else if (auto_rd) begin
            // Read stepping moves index before the fetch
            index <= index_step;
        end else if (done && !op_rd && stepping) begin
            // Write stepping moves index after the write
            index <= index_step;
        end
    end

    // ------------------------------------------------------------
    // Value register halves
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            host_word <= ifca_pkg::VALUE_RESET;
            fab_word  <= ifca_pkg::VALUE_RESET;
        end else begin
            if (wr_val && !pending) begin
                host_word <= reg_wdata_in;
            end
            // Capture in the same edge pending drops
            if (done && op_rd) begin
                fab_word <= fab_rsp_in.rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Fabric request
    // ------------------------------------------------------------
    always_comb begin
        fab_req_out       = '0;
        fab_req_out.req   = (state == IFCA_ISSUE);
        fab_req_out.rd    = op_rd;
        fab_req_out.index = index;
        fab_req_out.lanes = lanes;
        fab_req_out.wdata = merged;
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    wire [31:0] cmd_view = {pending, dir_read, step_up, step_down,
                            8'h00, lanes, index};
    wire [31:0] val_view = dir_read ? fab_word : host_word;
    wire [31:0] rd_mux   = !reg_rd_in ? 32'h0000_0000 :
                           hit_cmd    ? cmd_view :
                           hit_val    ? val_view : 32'h0000_0000;

    // Read data one cycle after the strobe
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            reg_rdata_out <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_pending_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        start_cmd |=> pending) else $error("pending not set by start");
    chk_pending_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (pending && !done) |=> pending) else $error("pending dropped early");
    chk_read_capture: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (done && op_rd) |=> (!pending && fab_word == $past(fab_rsp_in.rdata)))
        else $error("read data not captured at completion");
    chk_dir_issue: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (start_cmd && !reg_wdata_in[ifca_pkg::DIRECTION_BIT]) |=>
        (fab_req_out.req && !fab_req_out.rd))
        else $error("write command issued wrong direction");
    chk_dir_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (start_cmd && reg_wdata_in[ifca_pkg::DIRECTION_BIT]) |=>
        (fab_req_out.req && fab_req_out.rd))
        else $error("read command issued wrong direction");
    chk_step_up_wr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (done && !op_rd && step_up) |=> index == $past(index) + 16'h0001)
        else $error("step-up after write wrong");
    chk_step_up_rd: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (auto_rd && step_up) |=> (pending && index == $past(index) + 16'h0001))
        else $error("step-up on read wrong");
    chk_step_down: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (auto_rd && step_down && !step_up) |=> index == $past(index) - 16'h0001)
        else $error("step-down on read wrong");
    chk_lane_keep: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (fab_req_out.req && !lanes[0]) |-> fab_req_out.wdata[7:0] == fab_cur_in[7:0])
        else $error("unselected lane overwritten");
    chk_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (reg_rd_in && hit_cmd) |=> reg_rdata_out[27:20] == 8'h00)
        else $error("reserved bits not zero");

    cov_read_op: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        done && op_rd);
    cov_write_op: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        done && !op_rd);
    cov_auto_read: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        auto_rd);

endmodule
`default_nettype wire

//--- ifca_pkg.sv
// Package: register map, command fields and carriers for the indirect fabric access port
`default_nettype none

package ifca_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] VALUE_OFFSET   = 12'h1ac; // Transfer word register
    localparam logic [11:0] COMMAND_OFFSET = 12'h1b0; // Command register

    // ------------------------------------------------------------
    // Command field positions
    // ------------------------------------------------------------
    localparam int PENDING_BIT   = 31; // Access pending flag
    localparam int DIRECTION_BIT = 30; // 1 read, 0 write
    localparam int STEP_UP_BIT   = 29; // Auto step-up
    localparam int STEP_DOWN_BIT = 28; // Auto step-down
    localparam int LANE_LSB      = 16; // Lane select 19:16
    localparam int INDEX_LSB     = 0;  // Target index 15:0

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
    localparam logic [3:0]  LANE_RESET  = 4'h0;
    localparam logic [15:0] INDEX_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Request toward the fabric register file
    typedef struct packed {
        logic        req;   // One-cycle request strobe
        logic        rd;    // 1 read, 0 write
        logic [15:0] index; // Fabric register number
        logic [3:0]  lanes; // Byte lanes for a write
        logic [31:0] wdata; // Write word
    } ifca_fab_req_t;

    // Answer from the fabric register file
    typedef struct packed {
        logic        ack;   // One-cycle completion strobe
        logic [31:0] rdata; // Read word, valid with ack
    } ifca_fab_rsp_t;

endpackage

`default_nettype wire

//--- ifca_lane_merge.sv
// Byte-lane merge for a fabric write: selected lanes take new data
`timescale 1ns/100ps
`default_nettype none

module ifca_lane_merge #(
    parameter int LANES = 4 // Byte lanes per word
) (
    // Data in
    input  wire logic [LANES*8-1:0] old_in,
    input  wire logic [LANES*8-1:0] new_in,
    input  wire logic [LANES-1:0]   lanes_in,
    // Data out
    output logic      [LANES*8-1:0] merged_out
);

    // ------------------------------------------------------------
    // Per-lane select
    // ------------------------------------------------------------
    for (genvar n = 0; n < LANES; n++) begin : g_lane
        // Unselected lanes keep the old byte
        assign merged_out[n*8 +: 8] = lanes_in[n] ? new_in[n*8 +: 8] : old_in[n*8 +: 8];
    end

endmodule
`default_nettype wire

//--- ifca_fabric_model.sv
// Behavioural model of the fabric register file behind the access port
`timescale 1ns/100ps
`default_nettype none

module ifca_fabric_model (
    // Clock and reset
    input  wire logic                    clk_sys_in,
    input  wire logic                    rst_in,
    // Answer delay in cycles after the request
    input  wire logic [7:0]              delay_in,
    // Fabric side of the port
    input  wire ifca_pkg::ifca_fab_req_t req_in,
    output var  ifca_pkg::ifca_fab_rsp_t rsp_out,
    output logic      [31:0]             cur_out
);
    // ------------------------------------------------------------
    // Storage and answer state
    // ------------------------------------------------------------
    logic [31:0] mem [0:255]; // Only low index byte decoded, enough here
    logic [7:0]  count;       // Cycles left before the answer
    logic        busy;        // One access outstanding
    logic        ack;         // Completion strobe
    logic [31:0] word;        // Last word answered

    // Known pattern so expectations derive from the index
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 32'h5a5a_0000 | i;
        end
    end

    // Current contents feed the lane merge in the request cycle
    assign cur_out = mem[req_in.index[7:0]];

    // Released data lines show the inverse, never a stale copy
    assign rsp_out.ack   = ack;
    assign rsp_out.rdata = ack ? word : ~word;

    // Take the request, store a merged write, answer after the delay
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            busy  <= 1'b0;
            count <= 8'h00;
            ack   <= 1'b0;
            word  <= 32'h0000_0000;
        end else begin
            ack <= 1'b0;
            if (req_in.req) begin
                busy  <= 1'b1;
                count <= delay_in;
                if (!req_in.rd) begin
                    mem[req_in.index[7:0]] <= req_in.wdata;
                end
            end else if (busy && count == 8'h00) begin
                busy <= 1'b0;
                ack  <= 1'b1;
                word <= mem[req_in.index[7:0]];
            end else if (busy) begin
                count <= count - 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

//--- indirect_fabric_csr_access_tb_top.sv
// Self-checking testbench for the indirect fabric access port
`timescale 1ns/100ps
`default_nettype none

module indirect_fabric_csr_access_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [11:0] CMD = ifca_pkg::COMMAND_OFFSET; // Command register
    localparam logic [11:0] VAL = ifca_pkg::VALUE_OFFSET;   // Value register
    logic                    clk_sys_in = 1'b0;
    logic                    rst_in     = 1'b1;
    logic [11:0]             reg_addr   = 12'h000;
    logic [31:0]             reg_wdata  = 32'h0000_0000;
    logic                    reg_wr     = 1'b0;
    logic                    reg_rd     = 1'b0;
    logic [31:0]             reg_rdata;
    logic [7:0]              delay      = 8'h01;
    ifca_pkg::ifca_fab_req_t fab_req;
    ifca_pkg::ifca_fab_rsp_t fab_rsp;
    logic [31:0]             fab_cur;
    int                      fail_count  = 0;
    int                      comparisons = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    ifca_access_port uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .fab_req_out(fab_req), .fab_rsp_in(fab_rsp),
        .fab_cur_in(fab_cur));
    ifca_fabric_model fabric (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .delay_in(delay),
        .req_in(fab_req), .rsp_out(fab_rsp), .cur_out(fab_cur));

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Poll the pending flag under a bounded count
    task automatic wait_idle(output logic [31:0] d);
        int n;
        n = 0;
        do begin
            rd(CMD, d);
            n++;
        end while (d[31] !== 1'b0 && n < 40);
        chk({31'h0, d[31]}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_map;
        logic [31:0] d;
        rd(CMD, d);
        chk(d, 32'h0000_0000);
        rd(VAL, d);
        chk(d, ifca_pkg::VALUE_RESET);
        wr(12'h1b4, 32'hffff_ffff);
        rd(12'h1b4, d);
        chk(d, 32'h0000_0000);
        wr(CMD, 32'h7fff_ffff);
        rd(CMD, d);
        chk(d, 32'h700f_ffff);
        wr(CMD, 32'h0000_0000);
    endtask

    // Slow fabric, write with lanes 0 and 2 only, then read back
    task automatic t_lane_write;
        logic [31:0] d;
        delay = 8'h05;
        wr(VAL, 32'haabb_ccdd);
        wr(CMD, 32'h8005_0005);
        rd(CMD, d);
        chk(d & 32'h8000_0000, 32'h8000_0000);
        wait_idle(d);
        wr(CMD, 32'hc000_0005);
        wait_idle(d);
        rd(VAL, d);
        chk(d, 32'h5abb_00dd);
        delay = 8'h01;
    endtask

    // Stepping write: launch by value write, index moves at completion
    task automatic step_write(input logic [31:0] c, input logic [15:0] n, input logic [31:0] v);
        logic [31:0] d;
        wr(CMD, c);
        wr(VAL, v);
        wait_idle(d);
        chk(d, {c[31:16], n});
        rd(VAL, d);
        chk(d, v);
        wr(CMD, {16'hc00f, c[15:0]});
        wait_idle(d);
        rd(VAL, d);
        chk(d, v);
    endtask

    // Stepping read: value read moves index and fetches the next word
    task automatic step_read(input logic [31:0] c, input logic [15:0] n);
        logic [31:0] d;
        wr(CMD, c);
        wait_idle(d);
        rd(VAL, d);
        chk(d, {16'h5a5a, c[15:0]});
        wait_idle(d);
        chk(d, {c[31:16] & 16'h7fff, n});
        wr(CMD, {16'h400f, n});
        rd(VAL, d);
        chk(d, {16'h5a5a, n});
        rd(CMD, d);
        chk(d, {16'h400f, n});
    endtask

    // ------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_reset_map();
        t_lane_write();
        step_write(32'h200f_0010, 16'h0011, 32'h1234_5678);
        step_write(32'h100f_0050, 16'h004f, 32'h0000_0001);
        step_write(32'h300f_0070, 16'h0071, 32'hcafe_0002);
        step_read(32'he00f_0040, 16'h0041);
        step_read(32'hd00f_0020, 16'h001f);
        step_read(32'hf00f_0060, 16'h0061);
        end_of_test();
    end

    // Whole run is under two hundred cycles; cut a hang well beyond that
    initial begin
        #400000;
        fail_count++;
        end_of_test();
    end
endmodule

`default_nettype wire
